// >>> logic/tclm_defs.vh
// constants for the temperature conversion and limit monitor
`ifndef TCLM_DEFS_VH
`define TCLM_DEFS_VH
// clock and timing, in kHz and ms
`define TCLM_CLK_KHZ 50000
`define TCLM_FAST_MS 6
`define TCLM_CONV_MS 240
`define TCLM_SPS_CONV_MS 60
`define TCLM_SPS_IDLE_MS 940
// register byte offsets
`define TCLM_A_TEMP_MSB 8'h00
`define TCLM_A_TEMP_LSB 8'h01
`define TCLM_A_STATUS 8'h02
`define TCLM_A_CONFIG 8'h03
`define TCLM_A_CRIT_MSB 8'h04
`define TCLM_A_CRIT_LSB 8'h05
`define TCLM_A_HIGH_MSB 8'h06
`define TCLM_A_HIGH_LSB 8'h07
`define TCLM_A_LOW_MSB 8'h08
`define TCLM_A_LOW_LSB 8'h09
// config fields
`define TCLM_CFG_RES16 7
`define TCLM_CFG_MODE_HI 6
`define TCLM_CFG_MODE_LO 5
`define TCLM_CFG_IRQ 4
`define TCLM_CFG_CT_POL 3
`define TCLM_CFG_INT_POL 2
`define TCLM_CFG_RST 8'h00
// modes
`define TCLM_MODE_NORMAL 2'h0
`define TCLM_MODE_ONESHOT 2'h1
`define TCLM_MODE_SPS 2'h2
`define TCLM_MODE_OFF 2'h3
// setpoint resets and fast limits, 1/128 C per lsb
`define TCLM_CRIT_RST 16'h4980
`define TCLM_HIGH_RST 16'h2000
`define TCLM_LOW_RST 16'h0500
`define TCLM_FAST_CRIT 16'h4980
`define TCLM_FAST_HIGH 16'h2000
// fixed upper bits of the serial address
`define TCLM_I2C_BASE 5'h12
`endif

// >>> logic/tclm_i2c_slave.v
// serial bus slave turning byte transfers into register strobes
`timescale 1ns/100ps
`include "tclm_defs.vh"
module tclm_i2c_slave (
    input wire mclk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire [6:0] dev_addr_i,
    input wire [7:0] reg_rdata_i,
    output wire [7:0] reg_addr_o,
    output wire [7:0] reg_wdata_o,
    output wire reg_wr_o,
    output wire reg_rd_o,
    output wire sda_oe_n_o
);
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_AACK = 3'd2;
    localparam S_WR = 3'd3;
    localparam S_WACK = 3'd4;
    localparam S_RD = 3'd5;
    localparam S_RACK = 3'd6;
    localparam S_RNXT = 3'd7;
    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg [7:0] sh_r;
    reg [7:0] ptr_r;
    reg [7:0] addr_r;
    reg [7:0] wdata_r;
    reg [1:0] ld_r;
    reg rw_r;
    reg first_r;
    reg oe_n_r;
    reg wr_r;
    reg rd_r;
    reg scl_d_r;
    reg sda_d_r;
    wire scl_rise = scl_i & ~scl_d_r;
    wire scl_fall = ~scl_i & scl_d_r;
    wire start = scl_i & scl_d_r & sda_d_r & ~sda_i;
    wire stop = scl_i & scl_d_r & ~sda_d_r & sda_i;

    assign reg_addr_o = addr_r;
    assign reg_wdata_o = wdata_r;
    assign reg_wr_o = wr_r;
    assign reg_rd_o = rd_r;
    assign sda_oe_n_o = oe_n_r;

    // bit engine; serial clock edges only move data
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_r <= S_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            ld_r <= 2'h0;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            oe_n_r <= 1'b1;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_i;
            sda_d_r <= sda_i;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            ld_r <= {ld_r[0], 1'b0};
            // read data is back two cycles after the strobe
            if (ld_r[1])
            begin
                sh_r <= reg_rdata_i;
                oe_n_r <= reg_rdata_i[7];
                cnt_r <= 4'h0;
            end
            if (start)
            begin
                state_r <= S_ADDR;
                cnt_r <= 4'h0;
                first_r <= 1'b1;
                oe_n_r <= 1'b1;
            end
            else if (stop)
            begin
                state_r <= S_IDLE;
                oe_n_r <= 1'b1;
            end
            else
            begin
                case (state_r)
                    S_ADDR, S_WR:
                    begin
                        if (scl_rise)
                        begin
                            sh_r <= {sh_r[6:0], sda_i};
                            cnt_r <= cnt_r + 4'h1;
                        end
                        else if (scl_fall && cnt_r == 4'h8 && state_r == S_ADDR)
                        begin
                            // strap-derived address match
                            if (sh_r[7:1] == dev_addr_i)
                            begin
                                oe_n_r <= 1'b0;
                                rw_r <= sh_r[0];
                                state_r <= S_AACK;
                            end
                            else
                                state_r <= S_IDLE;
                        end
                        else if (scl_fall && cnt_r == 4'h8)
                        begin
                            oe_n_r <= 1'b0;
                            state_r <= S_WACK;
                            first_r <= 1'b0;
                            if (first_r)
                                ptr_r <= sh_r;
                            else
                            begin
                                wr_r <= 1'b1;
                                wdata_r <= sh_r;
                                addr_r <= ptr_r;
                                ptr_r <= ptr_r + 8'h01;
                            end
                        end
                    end
                    S_AACK, S_RNXT:
                    begin
                        if (scl_fall)
                        begin
                            cnt_r <= 4'h0;
                            if (rw_r)
                            begin
                                rd_r <= 1'b1;
                                ld_r[0] <= 1'b1;
                                addr_r <= ptr_r;
                                ptr_r <= ptr_r + 8'h01;
                                state_r <= S_RD;
                            end
                            else
                            begin
                                oe_n_r <= 1'b1;
                                state_r <= S_WR;
                            end
                        end
                    end
                    S_WACK:
                    begin
                        if (scl_fall)
                        begin
                            oe_n_r <= 1'b1;
                            cnt_r <= 4'h0;
                            state_r <= S_WR;
                        end
                    end
                    S_RD:
                    begin
                        if (scl_fall && cnt_r == 4'h7)
                        begin
                            oe_n_r <= 1'b1;
                            state_r <= S_RACK;
                        end
                        else if (scl_fall)
                        begin
                            cnt_r <= cnt_r + 4'h1;
                            sh_r <= {sh_r[6:0], 1'b0};
                            oe_n_r <= sh_r[6];
                        end
                    end
                    S_RACK:
                    begin
                        if (scl_rise)
                            state_r <= sda_i ? S_IDLE : S_RNXT;
                    end
                    default:
                    begin
                        oe_n_r <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // tclm_i2c_slave

// >>> logic/tclm_monitor.v
// conversion sequencer, limit compare, alert pins and register file
`timescale 1ns/100ps
`include "tclm_defs.vh"
module tclm_monitor #(
    parameter integer FAST_CYCLES = `TCLM_FAST_MS * `TCLM_CLK_KHZ,
    parameter integer CONV_CYCLES = `TCLM_CONV_MS * `TCLM_CLK_KHZ,
    parameter integer SPS_CONV_CYCLES = `TCLM_SPS_CONV_MS * `TCLM_CLK_KHZ,
    parameter integer SPS_IDLE_CYCLES = `TCLM_SPS_IDLE_MS * `TCLM_CLK_KHZ
) (
    input wire mclk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [7:0] reg_rdata_o,
    input wire [15:0] temp_sample_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output wire sda_oe_n_o,
    input wire addr_strap_lo_i,
    input wire addr_strap_hi_i,
    output reg critical_alert_out_o,
    output reg critical_alert_out_oe_n_o,
    output reg temp_alert_out_o,
    output reg temp_alert_out_oe_n_o
);
    localparam ST_FAST = 2'd0;
    localparam ST_CONV = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_OFF = 2'd3;
    localparam [25:0] FAST_LD = FAST_CYCLES[25:0] - 26'h1;
    localparam [25:0] CONV_LD = CONV_CYCLES[25:0] - 26'h1;
    localparam [25:0] SPS_LD = SPS_CONV_CYCLES[25:0] - 26'h1;
    localparam [25:0] IDLE_LD = SPS_IDLE_CYCLES[25:0] - 26'h1;

    reg [7:0] cfg_r;
    reg [15:0] crit_r;
    reg [15:0] high_r;
    reg [15:0] low_r;
    reg [15:0] temp_r;
    reg [2:0] flags_r;
    reg not_ready_r;
    reg [7:0] rdata_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [25:0] cnt_r;
    reg [25:0] cnt_nxt;
    reg kick_r;
    reg ct_act_r;
    reg int_act_r;
    reg [1:0] scl_s_r;
    reg [1:0] sda_s_r;
    reg [1:0] alo_s_r;
    reg [1:0] ahi_s_r;

    wire [7:0] i2c_addr;
    wire [7:0] i2c_wdata;
    wire i2c_wr;
    wire i2c_rd;

    // two-stage synchronisers for the serial bus and address strap inputs
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            alo_s_r <= 2'h0;
            ahi_s_r <= 2'h0;
        end
        else
        begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            alo_s_r <= {alo_s_r[0], addr_strap_lo_i};
            ahi_s_r <= {ahi_s_r[0], addr_strap_hi_i};
        end
    end

    // serial port; address low bits from the straps
    tclm_i2c_slave u_i2c (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .scl_i(scl_s_r[1]),
        .sda_i(sda_s_r[1]),
        .dev_addr_i({`TCLM_I2C_BASE, ahi_s_r[1], alo_s_r[1]}),
        .reg_rdata_i(rdata_r),
        .reg_addr_o(i2c_addr),
        .reg_wdata_o(i2c_wdata),
        .reg_wr_o(i2c_wr),
        .reg_rd_o(i2c_rd),
        .sda_oe_n_o(sda_oe_n_o)
    );

    // access merge; the plain port wins a same-cycle clash
    wire wr = reg_wr_i | i2c_wr;
    wire rd = reg_rd_i | i2c_rd;
    wire [7:0] waddr = reg_wr_i ? reg_addr_i : i2c_addr;
    wire [7:0] wdata = reg_wr_i ? reg_wdata_i : i2c_wdata;
    wire [7:0] raddr = reg_rd_i ? reg_addr_i : i2c_addr;
    wire [1:0] mode = cfg_r[`TCLM_CFG_MODE_HI:`TCLM_CFG_MODE_LO];
    wire res16 = cfg_r[`TCLM_CFG_RES16];
    wire irq_mode = cfg_r[`TCLM_CFG_IRQ];
    wire cfg_wr = wr && (waddr == `TCLM_A_CONFIG);

    // conversion finishes when the running counter hits zero
    wire converting = (state_r == ST_FAST) || (state_r == ST_CONV);
    wire done = converting && (cnt_r == 26'h0);
    wire fast = (state_r == ST_FAST);

    // next state of the internally timed sequencer
    always @*
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r - 26'h1;
        if (kick_r)
        begin
            // mode write restarts or stops conversions
            if (mode == `TCLM_MODE_OFF)
                state_nxt = ST_OFF;
            else
            begin
                state_nxt = ST_CONV;
                cnt_nxt = (mode == `TCLM_MODE_SPS) ? SPS_LD : CONV_LD;
            end
        end
        else
        begin
            case (state_r)
                ST_FAST, ST_CONV:
                begin
                    if (cnt_r == 26'h0)
                    begin
                        case (mode)
                            `TCLM_MODE_NORMAL:
                            begin
                                state_nxt = ST_CONV; // back to back
                                cnt_nxt = CONV_LD;
                            end
                            `TCLM_MODE_SPS:
                            begin
                                state_nxt = ST_WAIT;
                                cnt_nxt = IDLE_LD;
                            end
                            default:
                            begin
                                state_nxt = ST_OFF; // one-shot ends in shutdown
                            end
                        endcase
                    end
                end
                ST_WAIT:
                begin
                    if (cnt_r == 26'h0)
                    begin
                        state_nxt = ST_CONV;
                        cnt_nxt = SPS_LD;
                    end
                end
                default:
                begin
                    cnt_nxt = cnt_r;
                end
            endcase
        end
    end

    // sequencer registers; fast conversion first
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_FAST;
            cnt_r <= FAST_LD;
            kick_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            kick_r <= cfg_wr;
        end
    end

    // limit comparison on the selected resolution
    wire [15:0] t_cmp = res16 ? temp_sample_i : {temp_sample_i[15:3], 3'h0};
    wire [15:0] lim_crit = fast ? `TCLM_FAST_CRIT : crit_r;
    wire [15:0] lim_high = fast ? `TCLM_FAST_HIGH : high_r;
    wire crit_hit = $signed(t_cmp) > $signed(lim_crit);
    wire high_hit = $signed(t_cmp) > $signed(lim_high);
    wire low_hit = !fast && ($signed(t_cmp) < $signed(low_r));

    // result capture, flags in the low bits in 13-bit mode
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            temp_r <= 16'h0000;
            flags_r <= 3'h0;
            not_ready_r <= 1'b1;
        end
        else if (done)
        begin
            temp_r <= res16 ? temp_sample_i
                : {temp_sample_i[15:3], crit_hit, high_hit, low_hit};
            flags_r <= {crit_hit, high_hit, low_hit};
            not_ready_r <= 1'b0;
        end
        else if (rd && raddr == `TCLM_A_TEMP_MSB)
            not_ready_r <= 1'b1;
    end

    // alert state; a new hit beats a read clear
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ct_act_r <= 1'b0;
            int_act_r <= 1'b0;
        end
        else if (done && !irq_mode)
        begin
            ct_act_r <= crit_hit;
            int_act_r <= high_hit | low_hit; // comparator follows result
        end
        else
        begin
            if (done && crit_hit)
                ct_act_r <= 1'b1;
            else if (irq_mode && rd)
                ct_act_r <= 1'b0;
            if (done && (high_hit | low_hit))
                int_act_r <= 1'b1;
            else if (irq_mode && rd)
                int_act_r <= 1'b0;
        end
    end

    // open-drain pins released at their high level, polarity set means active high
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sda_o <= 1'b0;
            critical_alert_out_o <= 1'b0;
            temp_alert_out_o <= 1'b0;
            critical_alert_out_oe_n_o <= 1'b1;
            temp_alert_out_oe_n_o <= 1'b1;
        end
        else
        begin
            sda_o <= 1'b0;
            critical_alert_out_o <= 1'b0;
            temp_alert_out_o <= 1'b0;
            critical_alert_out_oe_n_o <= ~(cfg_r[`TCLM_CFG_CT_POL] ^ ct_act_r);
            temp_alert_out_oe_n_o <= ~(cfg_r[`TCLM_CFG_INT_POL] ^ int_act_r);
        end
    end

    // register writes; normal mode and defaults after reset
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cfg_r <= `TCLM_CFG_RST;
            crit_r <= `TCLM_CRIT_RST;
            high_r <= `TCLM_HIGH_RST;
            low_r <= `TCLM_LOW_RST;
        end
        else if (wr)
        begin
            if (waddr == `TCLM_A_CONFIG)
                cfg_r <= wdata;
            else if (waddr == `TCLM_A_CRIT_MSB)
                crit_r[15:8] <= wdata;
            else if (waddr == `TCLM_A_CRIT_LSB)
                crit_r[7:0] <= wdata;
            else if (waddr == `TCLM_A_HIGH_MSB)
                high_r[15:8] <= wdata;
            else if (waddr == `TCLM_A_HIGH_LSB)
                high_r[7:0] <= wdata;
            else if (waddr == `TCLM_A_LOW_MSB)
                low_r[15:8] <= wdata;
            else if (waddr == `TCLM_A_LOW_LSB)
                low_r[7:0] <= wdata;
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_r <= 8'h00;
        else if (rd)
        begin
            if (raddr == `TCLM_A_TEMP_MSB)
                rdata_r <= temp_r[15:8];
            else if (raddr == `TCLM_A_TEMP_LSB)
                rdata_r <= temp_r[7:0];
            else if (raddr == `TCLM_A_STATUS)
                rdata_r <= {not_ready_r, flags_r, 4'h0};
            else if (raddr == `TCLM_A_CONFIG)
                rdata_r <= cfg_r;
            else if (raddr == `TCLM_A_CRIT_MSB)
                rdata_r <= crit_r[15:8];
            else if (raddr == `TCLM_A_CRIT_LSB)
                rdata_r <= crit_r[7:0];
            else if (raddr == `TCLM_A_HIGH_MSB)
                rdata_r <= high_r[15:8];
            else if (raddr == `TCLM_A_HIGH_LSB)
                rdata_r <= high_r[7:0];
            else if (raddr == `TCLM_A_LOW_MSB)
                rdata_r <= low_r[15:8];
            else if (raddr == `TCLM_A_LOW_LSB)
                rdata_r <= low_r[7:0];
            else
                rdata_r <= 8'h00;
        end
    end

    assign reg_rdata_o = rdata_r;
endmodule // tclm_monitor

// >>> test/tclm_monitor_checker.sv
// concurrent checks on the monitor top ports
`timescale 1ns/100ps
module tclm_monitor_checker #(
    parameter integer FAST_CYCLES = 20
) (
    input wire mclk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire [15:0] temp_sample_i,
    input wire scl_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    input wire critical_alert_out_o,
    input wire critical_alert_out_oe_n_o,
    input wire temp_alert_out_o,
    input wire temp_alert_out_oe_n_o
);
    reg [31:0] cnt_r;
    reg [7:0] cfg_r;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // cycles since reset release, shadow of config writes
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= 32'h0000_0000;
            cfg_r <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_r + {31'h0000_0000, ~&cnt_r};
            if (reg_wr_i && reg_addr_i == 8'h03)
                cfg_r <= reg_wdata_i;
        end
    end
    a_pins_open_drain: assert property (!sda_o && !critical_alert_out_o && !temp_alert_out_o)
        else $error("open-drain pin driven high");
    a_reset_idle: assert property ($fell(rst_i) |-> critical_alert_out_oe_n_o && temp_alert_out_oe_n_o && sda_oe_n_o)
        else $error("pins not released after reset");
    a_fast_crit: assert property (cnt_r == FAST_CYCLES + 3 |->
        critical_alert_out_oe_n_o == ($signed($past(temp_sample_i, 3)) <= 16'sh4980))
        else $error("critical pin wrong after fast conversion");
    a_fast_over: assert property (cnt_r == FAST_CYCLES + 3 |->
        temp_alert_out_oe_n_o == ($signed($past(temp_sample_i, 3)) <= 16'sh2000))
        else $error("over/under pin wrong after fast conversion");
    a_setpt_readback: assert property (reg_wr_i && reg_addr_i > 8'h03 && reg_addr_i < 8'h0a
        ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("setpoint readback differs");
    a_irq_read_clear: assert property (reg_rd_i && cfg_r[4] |-> ##2
        temp_alert_out_oe_n_o == !cfg_r[2] && critical_alert_out_oe_n_o == !cfg_r[3])
        else $error("read left an alert pending");
    a_shutdown_hold: assert property (reg_wr_i && reg_addr_i == 8'h03 && reg_wdata_i[6:5] == 2'b11
        && reg_wdata_i[4:2] == cfg_r[4:2] |-> ##4 $stable(temp_alert_out_oe_n_o) [*8])
        else $error("alert moved in shutdown");
    a_sda_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data line moved with clock high");
endmodule // tclm_monitor_checker

bind tclm_monitor tclm_monitor_checker #(.FAST_CYCLES(FAST_CYCLES)) u_chk (.*);

// >>> test/tclm_i2c_host.sv
// serial bus controller model writing one register
`timescale 1ns/100ps
module tclm_i2c_host (
    input wire sda_line_i,
    output reg scl_o,
    output reg sda_o
);
    // bus idle, both lines released
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // one bit, 160 ns: data set in low phase, sampled in high phase
    task bit_io(input b, output s);
    begin
        #65 sda_o = b;
        #55 scl_o = 1'b1;
        #20 s = sda_line_i;
        #20 scl_o = 1'b0;
    end
    endtask
    // start, address, pointer, data, stop; ok when all three acks seen
    task write_reg(input [6:0] dev, input [7:0] ptr, input [7:0] dat, output ok);
        reg [26:0] frame;
        reg s;
        integer i;
    begin
        frame = {dev, 2'b01, ptr, 1'b1, dat, 1'b1};
        ok = 1'b1;
        #37 sda_o = 1'b0;
        #80 scl_o = 1'b0;
        for (i = 26; i >= 0; i = i - 1)
        begin
            bit_io(frame[i], s);
            if (i % 9 == 0 && s)
                ok = 1'b0;
        end
        #65 sda_o = 1'b0;
        #55 scl_o = 1'b1;
        #80 sda_o = 1'b1;
        #200 ok = ok;
    end
    endtask
endmodule // tclm_i2c_host

// >>> test/tclm_monitor_tb_top.sv
// self-checking bench for the temperature monitor
`timescale 1ns/100ps
`include "tclm_defs.vh"
module tclm_monitor_tb_top;
    localparam integer FAST = 20;
    localparam integer CONV = 50;
    localparam [47:0] SP_RST = {`TCLM_CRIT_RST, `TCLM_HIGH_RST, `TCLM_LOW_RST};
    reg clk, rst, wr, rd, sl, sh, rd_d, ok;
    reg [7:0] addr, wdata, r8;
    reg [15:0] samp, s1, prev;
    reg [7:0] expq[$];
    wire [7:0] rdata;
    wire scl, hsda, sda_oe_n, ct_oe_n, int_oe_n;
    wire sda = hsda & sda_oe_n;
    integer errors, n_compared, i, m;
    integer cyc = 0;
    tclm_monitor #(.FAST_CYCLES(FAST), .CONV_CYCLES(CONV), .SPS_CONV_CYCLES(20),
        .SPS_IDLE_CYCLES(40)) dut (.mclk_i(clk), .rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .temp_sample_i(samp), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n),
        .addr_strap_lo_i(sl), .addr_strap_hi_i(sh), .critical_alert_out_o(),
        .critical_alert_out_oe_n_o(ct_oe_n), .temp_alert_out_o(),
        .temp_alert_out_oe_n_o(int_oe_n));
    tclm_i2c_host host (.sda_line_i(sda), .scl_o(scl), .sda_o(hsda));
    task cmp8(input [7:0] got, input [7:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task end_of_test;
    begin
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask
    task rd_reg(input [7:0] a, input [7:0] e);
    begin
        addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        // idle cycle so a following read never re-raises rd in the same step
        @(posedge clk);
    end
    endtask
    task pins(input c, input t);
    begin
        cmp8({7'h00, ct_oe_n}, {7'h00, c});
        cmp8({7'h00, int_oe_n}, {7'h00, t});
    end
    endtask
    task settle(input [15:0] s);
    begin
        samp <= s;
        repeat (CONV + 4) @(posedge clk);
    end
    endtask
    task do_reset(input [15:0] s);
    begin
        samp <= s;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (FAST + 6) @(posedge clk);
        pins(s <= 16'h4980, s <= 16'h2000);
        rd_reg(`TCLM_A_TEMP_MSB, s[15:8]);
    end
    endtask
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            errors = errors + 1;
            end_of_test;
        end
    end
    // read data land one cycle after the strobe
    always @(posedge clk)
    begin
        rd_d <= rd;
        if (rd_d)
            cmp8(rdata, expq.pop_front());
    end
    // main sequence
    initial
    begin
        {rst, wr, rd, addr, wdata, samp} = {3'h4, 32'h0000_0000};
        {errors, n_compared} = 0;
        prev = $urandom(32'h3c7ed6a6);
        {sh, sl} = prev[1:0];
        @(posedge clk);
        do_reset(16'h3000);
        rd_reg(`TCLM_A_CONFIG, `TCLM_CFG_RST);
        for (i = 4; i < 10; i = i + 1)
        begin
            r8 = $urandom;
            rd_reg(i[7:0], SP_RST[8 * (9 - i) +: 8]);
            wr_reg(i[7:0], r8);
            rd_reg(i[7:0], r8);
            wr_reg(i[7:0], SP_RST[8 * (9 - i) +: 8]);
        end
        rd_reg(8'h0a, 8'h00);
        for (i = 0; i < 3; i = i + 1)
        begin
            s1 = 16'h0800 + ($urandom % 16'h1700);
            settle(s1);
            rd_reg(`TCLM_A_TEMP_MSB, s1[15:8]);
            rd_reg(`TCLM_A_TEMP_LSB, {s1[7:3], 3'h0});
        end
        wr_reg(`TCLM_A_CONFIG, 8'h80);
        settle(s1 | 16'h0005);
        rd_reg(`TCLM_A_TEMP_LSB, s1[7:0] | 8'h05);
        wr_reg(`TCLM_A_CONFIG, 8'h00);
        settle(16'h0200);
        pins(1'b1, 1'b0);
        settle(16'h4c00);
        pins(1'b0, 1'b0);
        rd_reg(`TCLM_A_STATUS, 8'h60);
        wr_reg(`TCLM_A_CONFIG, 8'h0c);
        settle(16'h1000);
        pins(1'b0, 1'b0);
        settle(16'h3000);
        pins(1'b0, 1'b1);
        wr_reg(`TCLM_A_CONFIG, 8'h10);
        repeat (8) @(posedge clk);
        rd_reg(`TCLM_A_CONFIG, 8'h10);
        repeat (2) @(posedge clk);
        pins(1'b1, 1'b1);
        for (i = 0; i < 200 && int_oe_n !== 1'b0; i = i + 1)
            @(posedge clk);
        pins(1'b1, 1'b0);
        rd_reg(`TCLM_A_TEMP_MSB, 8'h30);
        repeat (2) @(posedge clk);
        pins(1'b1, 1'b1);
        prev = 16'h3000;
        for (m = 0; m < 4; m = m + 1)
        begin
            s1 = 16'h0800 + ($urandom % 16'h1700);
            samp <= s1;
            wr_reg(`TCLM_A_CONFIG, {1'b0, m[1:0], 5'h00});
            repeat (CONV + 4) @(posedge clk);
            prev = (m < 3) ? s1 : prev;
            rd_reg(`TCLM_A_TEMP_MSB, prev[15:8]);
            samp <= s1 ^ 16'h0400;
            repeat (2 * CONV) @(posedge clk);
            prev = (m == 0 || m == 2) ? (s1 ^ 16'h0400) : prev;
            rd_reg(`TCLM_A_TEMP_MSB, prev[15:8]);
        end
        r8 = $urandom;
        host.write_reg({`TCLM_I2C_BASE, sh, sl}, `TCLM_A_HIGH_LSB, r8, ok);
        cmp8({7'h00, ok}, 8'h01);
        @(posedge clk);
        rd_reg(`TCLM_A_HIGH_LSB, r8);
        host.write_reg({`TCLM_I2C_BASE, ~sh, sl}, `TCLM_A_HIGH_LSB, ~r8, ok);
        cmp8({7'h00, ok}, 8'h00);
        @(posedge clk);
        rd_reg(`TCLM_A_HIGH_LSB, r8);
        do_reset(16'h4a00);
        repeat (3) @(posedge clk);
        end_of_test;
    end
endmodule // tclm_monitor_tb_top
